// file: hdl/adcr_top.sv
// Function
// - result bits 9..2 in register bits 15..8
// - result bits 1..0 in register bits 7,6
// - single mode: done flag after selected input
// - scan mode: done flag after whole group
// - writing zero clears done flag; one ignored
// - done interrupt equals enable and done flag
// - single start converts once, then self-clears
// - scan start repeats group until cleared
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
module adcr_top
  import adcr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               standby,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  output adcr_core_req_t          core_req,
  input  wire logic [RES_W-1:0]   core_result,
  output logic                    conversion_done_irq,
  output logic                    irq
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcr_state_t;

  adcr_bus_req_t     req;
  logic [31:0]       rd_addr;
  logic [31:0]       rdata;

  // control/status fields
  logic              conversion_done_flag;
  logic              done_irq_enable;
  logic              conversion_start_bit;
  logic              scan_mode;
  logic              conversion_speed_select;
  logic [SEL_W-1:0]  input_select_field;

  // conversion state
  adcr_state_t       state;
  adcr_state_t       next_state;
  logic [SEL_W-1:0]  cur_ch;
  logic [SEL_W-1:0]  next_ch;
  logic              conv_fast;
  logic              timer_done;

  // result storage, one slot per input pair
  logic [RES_W-1:0]  result [4];

  // own interrupt status and mask
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;

  // standby acts as a reset for everything this block owns
  wire clr = rst | standby;

  // bus slave
  adcr_ahb_slave u_bus (
    .clk       (clk),
    .rst       (clr),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .req       (req),
    .rd_addr   (rd_addr),
    .rdata     (rdata)
  );

  // write decode
  wire wr_cs   = req.wr & (req.addr == ADDR_CTRL_STAT);
  wire wr_ists = req.wr & (req.addr == ADDR_IRQ_STATUS);
  wire wr_imsk = req.wr & (req.addr == ADDR_IRQ_MASK);
  wire [7:0] wd = req.wdata[7:0];

  // group bounds in scan mode
  wire [SEL_W-1:0] grp_base = {input_select_field[SEL_W-1], 2'b00};
  wire [SEL_W-1:0] first_ch = scan_mode ? grp_base : input_select_field;
  wire             at_last  = (cur_ch[1:0] == input_select_field[1:0]);

  // conversion events
  wire running   = (state == ST_CONV);
  wire sw_stop   = running & ~conversion_start_bit;
  wire chan_done = running & conversion_start_bit & timer_done;
  wire grp_done  = chan_done & (~scan_mode | at_last);
  wire single_end = chan_done & ~scan_mode;
  wire launch_idle = (state == ST_IDLE) & conversion_start_bit;
  wire relaunch  = chan_done & scan_mode;
  wire launch    = launch_idle | relaunch;

  // done flag: zero write clears, a one write is ignored, set wins
  wire flag_clr = wr_cs & ~wd[CS_DONE_BIT];
  wire next_done_flag = grp_done | (conversion_done_flag & ~flag_clr);

  // start bit: software write, else self-clear after a single conversion
  wire next_start = wr_cs ? wd[CS_START_BIT]
                  : (single_end ? 1'b0 : conversion_start_bit);

  // control/status register
  always_ff @(posedge clk) begin
    if (clr) begin
      conversion_done_flag    <= CS_RESET[CS_DONE_BIT];
      done_irq_enable         <= CS_RESET[CS_IE_BIT];
      conversion_start_bit    <= CS_RESET[CS_START_BIT];
      scan_mode               <= CS_RESET[CS_SCAN_BIT];
      conversion_speed_select <= CS_RESET[CS_SPEED_BIT];
      input_select_field      <= CS_RESET[CS_SEL_LSB +: SEL_W];
    end else begin
      conversion_done_flag <= next_done_flag;
      conversion_start_bit <= next_start;
      if (wr_cs) begin
        done_irq_enable         <= wd[CS_IE_BIT];
        scan_mode               <= wd[CS_SCAN_BIT];
        conversion_speed_select <= wd[CS_SPEED_BIT];
        input_select_field      <= wd[CS_SEL_LSB +: SEL_W];
      end
    end
  end

  // next channel: step through the group and wrap to its base
  assign next_ch = launch_idle ? first_ch
                 : (at_last ? grp_base : cur_ch + 3'h1);

  // sequencer state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (conversion_start_bit) next_state = ST_CONV;
      end
      ST_CONV: begin
        if (sw_stop | single_end) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      state  <= ST_IDLE;
      cur_ch <= '0;
    end else begin
      state <= next_state;
      if (launch) cur_ch <= next_ch;
    end
  end

  // speed is sampled at each launch so a mid-conversion write waits
  always_ff @(posedge clk) begin
    if (clr) conv_fast <= 1'b0;
    else if (launch) conv_fast <= conversion_speed_select;
  end

  // conversion timer
  adcr_conv_timer u_timer (
    .clk   (clk),
    .rst   (clr),
    .start (launch),
    .abort (sw_stop),
    .fast  (launch ? conversion_speed_select : conv_fast),
    .done  (timer_done)
  );

  // core request: start pulse and channel, both registered
  always_ff @(posedge clk) begin
    if (clr) begin
      core_req <= '0;
    end else begin
      core_req.start <= launch;
      if (launch) core_req.channel <= next_ch;
    end
  end

  // result capture; inputs 0-3 and 4-7 share slots a-d
  always_ff @(posedge clk) begin
    if (clr) begin
      for (int i = 0; i < 4; i++) result[i] <= '0;
    end else if (chan_done) begin
      result[cur_ch[1:0]] <= core_result;
    end
  end

  // interrupt status: write one clears, a new event wins
  wire [IRQ_W-1:0] irq_evt = {grp_done, chan_done};
  wire [IRQ_W-1:0] irq_w1c = wr_ists ? req.wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = irq_evt | (irq_status & ~irq_w1c);

  always_ff @(posedge clk) begin
    if (clr) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_imsk) irq_mask <= req.wdata[IRQ_W-1:0];
    end
  end

  // interrupt outputs
  always_ff @(posedge clk) begin
    if (clr) begin
      conversion_done_irq <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      conversion_done_irq <= done_irq_enable & conversion_done_flag;
      irq                 <= |(irq_status & irq_mask);
    end
  end

  // read views; low six result bits are always zero
  wire [15:0] res_a = {result[0], 6'h00};
  wire [15:0] res_b = {result[1], 6'h00};
  wire [15:0] res_c = {result[2], 6'h00};
  wire [15:0] res_d = {result[3], 6'h00};
  wire [7:0]  cs_view = {conversion_done_flag, done_irq_enable,
                         conversion_start_bit, scan_mode,
                         conversion_speed_select, input_select_field};

  // read mux; unmapped addresses read as zero
  assign rdata =
      (rd_addr == ADDR_RESULT_A)   ? {16'h0, res_a} :
      (rd_addr == ADDR_RESULT_B)   ? {16'h0, res_b} :
      (rd_addr == ADDR_RESULT_C)   ? {16'h0, res_c} :
      (rd_addr == ADDR_RESULT_D)   ? {16'h0, res_d} :
      (rd_addr == ADDR_CTRL_STAT)  ? {24'h0, cs_view} :
      (rd_addr == ADDR_IRQ_STATUS) ? {30'h0, irq_status} :
      (rd_addr == ADDR_IRQ_MASK)   ? {30'h0, irq_mask} :
                                     32'h0;

endmodule : adcr_top

// file: hdl/adcr_pkg.sv
package adcr_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_RESULT_A   = 32'h05fffee0;
  localparam logic [31:0] IDX_RESULT_B   = 32'h05fffee2;
  localparam logic [31:0] IDX_RESULT_C   = 32'h05fffee4;
  localparam logic [31:0] IDX_RESULT_D   = 32'h05fffee6;
  localparam logic [31:0] IDX_CTRL_STAT  = 32'h05fffef8;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'h05fffefa;
  localparam logic [31:0] IDX_IRQ_MASK   = 32'h05fffefb;

  localparam logic [31:0] ADDR_RESULT_A   = {IDX_RESULT_A[29:0], 2'b00};
  localparam logic [31:0] ADDR_RESULT_B   = {IDX_RESULT_B[29:0], 2'b00};
  localparam logic [31:0] ADDR_RESULT_C   = {IDX_RESULT_C[29:0], 2'b00};
  localparam logic [31:0] ADDR_RESULT_D   = {IDX_RESULT_D[29:0], 2'b00};
  localparam logic [31:0] ADDR_CTRL_STAT  = {IDX_CTRL_STAT[29:0], 2'b00};
  localparam logic [31:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[29:0], 2'b00};
  localparam logic [31:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK[29:0], 2'b00};

  // control/status field positions
  localparam int unsigned CS_DONE_BIT  = 7;
  localparam int unsigned CS_IE_BIT    = 6;
  localparam int unsigned CS_START_BIT = 5;
  localparam int unsigned CS_SCAN_BIT  = 4;
  localparam int unsigned CS_SPEED_BIT = 3;
  localparam int unsigned CS_SEL_LSB   = 0;
  localparam int unsigned SEL_W        = 3;
  localparam logic [7:0]  CS_RESET     = 8'h04;

  // result placement: ten bits left-justified in sixteen
  localparam int unsigned RES_W   = 10;
  localparam int unsigned RES_LSB = 6;

  // interrupt status layout
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_CHAN_BIT  = 0;
  localparam int unsigned IRQ_GROUP_BIT = 1;

  // conversion time in system cycles
  localparam int unsigned CNT_W         = 9;
  localparam logic [8:0]  CONV_CYC_SLOW = 9'd236;
  localparam logic [8:0]  CONV_CYC_FAST = 9'd134;
  // edges spent on launch and capture come off the count, so the whole
  // conversion from the start write stays within its limit
  localparam logic [8:0]  CONV_OVERHEAD = 9'd2;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } adcr_bus_req_t;

  typedef struct packed {
    logic             start;
    logic [SEL_W-1:0] channel;
  } adcr_core_req_t;

endpackage : adcr_pkg

// file: hdl/adcr_ahb_slave.sv
`timescale 1ns/100ps
module adcr_ahb_slave
  import adcr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  output adcr_bus_req_t      req,
  output logic [31:0]        rd_addr,
  input  wire logic [31:0]   rdata
);

  logic        wr_pend;
  logic        rd_pend;
  logic [31:0] addr;
  wire         accept = hsel & hreadyout & htrans[1];

  // reads take one wait state so a write just before them is visible
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr      <= 32'h0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
    end else begin
      wr_pend <= accept & hwrite & (hsize == HSIZE_WORD);
      rd_pend <= accept & ~hwrite;
      if (accept) addr <= haddr;
      if (accept & ~hwrite) hreadyout <= 1'b0;
      else if (rd_pend) hreadyout <= 1'b1;
      if (rd_pend) hrdata <= rdata;
    end
  end

  // write data stands in the data phase, applied at its end
  assign req       = '{wr: wr_pend, addr: addr, wdata: hwdata};
  assign rd_addr   = addr;
  assign hresp     = 1'b0; // always okay

endmodule : adcr_ahb_slave

// file: hdl/adcr_conv_timer.sv
`timescale 1ns/100ps
module adcr_conv_timer
  import adcr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       fast,
  output logic            done
);

  logic [CNT_W-1:0] cnt;

  // counts down the conversion time; done pulses once at the end
  always_ff @(posedge clk) begin
    if (rst | abort) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      if (start) cnt <= (fast ? CONV_CYC_FAST : CONV_CYC_SLOW) - CONV_OVERHEAD;
      else if (cnt != '0) cnt <= cnt - 1'b1;
      done <= ~start & (cnt == 9'h1);
    end
  end

endmodule : adcr_conv_timer

// file: test/adcr_assertions.sv
`timescale 1ns/100ps
module adcr_checker
  import adcr_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             standby,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hreadyout,
  input wire logic [31:0]      hrdata,
  input wire logic             hresp,
  input wire adcr_core_req_t   core_req,
  input wire logic [RES_W-1:0] core_result,
  input wire logic             conversion_done_irq,
  input wire logic             irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a transfer accepted by the slave
  wire take = hsel && htrans[1] && hreadyout;

  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_start_spaced: assert property (core_req.start |=> !core_req.start [*8])
    else $error("start pulses too close");
  a_chan_steady: assert property (!core_req.start && !standby |=>
    core_req.start || $stable(core_req.channel))
    else $error("channel moved without a start");
  a_reset_quiet: assert property ($fell(rst) |-> !irq && !conversion_done_irq
    && !core_req.start && hreadyout)
    else $error("outputs active after reset");
  a_standby_stops: assert property (standby |=> !core_req.start && !irq
    && !conversion_done_irq)
    else $error("activity during standby");
  a_result_zeros: assert property (take && !hwrite && haddr[31:5] == ADDR_RESULT_A[31:5]
    |=> ##1 hrdata[5:0] == 6'h00 && hrdata[31:16] == 16'h0000)
    else $error("result unused bits set");
  a_ctrl_upper: assert property (take && !hwrite && haddr == ADDR_CTRL_STAT
    |=> ##1 hrdata[31:8] == 24'h000000)
    else $error("control upper bits set");
endmodule : adcr_checker

bind adcr_top adcr_checker chk (.clk(clk), .rst(rst), .standby(standby), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_req(core_req),
  .core_result(core_result), .conversion_done_irq(conversion_done_irq), .irq(irq));

// file: test/adcr_core_model.sv
`timescale 1ns/100ps
module adcr_core_model
  import adcr_pkg::*;
(
  input  wire logic           clk,
  input  wire adcr_core_req_t core_req,
  output logic [RES_W-1:0]    core_result
);
  logic [SEL_W-1:0] held  = 3'h0;
  logic             busy  = 1'b0;
  logic [RES_W-1:0] noise = 10'h155;

  // latch the input on start; noise keeps idle pins from looking valid
  always_ff @(posedge clk) begin
    noise <= ~noise;
    if (core_req.start) begin
      held <= core_req.channel;
      busy <= 1'b1;
    end
  end
  // each input yields a value naming it, so a swapped slot shows
  assign core_result = busy ? {held, 4'h9, ~held} : noise;
endmodule : adcr_core_model

// file: test/tb_adc_control_result_regs.sv
`timescale 1ns/100ps
module tb_adc_control_result_regs;
  import adcr_pkg::*;
  logic                 clk = 1'b0, rst = 1'b1, standby = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]           htrans = 2'b00;
  logic [2:0]           hsize = HSIZE_WORD;
  logic                 hreadyout, hresp, conversion_done_irq, irq;
  adcr_core_req_t       core_req;
  logic [RES_W-1:0]     core_result;
  int                   mismatches = 0, checks_done = 0;

  always #5 clk = ~clk;

  adcr_top uut (.clk(clk), .rst(rst), .standby(standby), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .core_req(core_req), .core_result(core_result),
    .conversion_done_irq(conversion_done_irq), .irq(irq));
  adcr_core_model core (.clk(clk), .core_req(core_req), .core_result(core_result));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic cmp(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp

  // address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk);
    haddr <= a; htrans <= 2'b10; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp($sformatf("reg %h", a), e, q);
  endtask : rd

  function automatic logic [31:0] res(input logic [2:0] ch);
    return {16'h0, ch, 4'h9, ~ch, 6'h00};
  endfunction : res

  // wait for the done interrupt; n counts edges from the start write to the
  // flag, which must not exceed the limit c; c of zero skips the window
  task automatic wirq(input int c);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (conversion_done_irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    cmp("irq_wait", 1, n < 2000 && (c == 0 || (n >= c - 4 && n <= c)));
  endtask : wirq

  task automatic quiet;
    int n;
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (core_req.start !== 1'b0) n++;
    end
    cmp("no_start", 0, n);
  endtask : quiet

  task automatic t_reset;
    rd(ADDR_CTRL_STAT, {24'h0, CS_RESET});
    for (int i = 0; i < 4; i++) rd(ADDR_RESULT_A + 32'(8 * i), 32'h0);
    wr(ADDR_RESULT_A, 32'hffffffff);
    rd(ADDR_RESULT_A, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_CTRL_STAT + 32'h100, 32'h0);
    $display("t_reset end");
  endtask : t_reset

  task automatic t_single(input logic [2:0] ch, input logic f);
    wr(ADDR_CTRL_STAT, {24'h0, 4'b0110, f, ch});
    wirq(f ? 134 : 236);
    rd(ADDR_CTRL_STAT, {24'h0, 4'b1100, f, ch});
    rd(ADDR_RESULT_A + 32'(8 * ch[1:0]), res(ch));
    wr(ADDR_CTRL_STAT, {24'h0, 4'b1000, f, ch});
    repeat (2) @(posedge clk);
    cmp("done_irq", 0, conversion_done_irq);
    rd(ADDR_CTRL_STAT, {24'h0, 4'b1000, f, ch});
    wr(ADDR_CTRL_STAT, {24'h0, 4'b0100, f, ch});
    rd(ADDR_CTRL_STAT, {24'h0, 4'b0100, f, ch});
    cmp("done_irq", 0, conversion_done_irq);
    $display("t_single end");
  endtask : t_single

  task automatic t_irq;
    logic [31:0] q;
    wr(ADDR_IRQ_STATUS, 32'h3);
    wr(ADDR_IRQ_MASK, 32'h1);
    rd(ADDR_IRQ_MASK, 32'h1);
    t_single(3'd6, 1'b1);
    cmp("irq", 1, irq);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, q);
    cmp("chan_done", 1, q[IRQ_CHAN_BIT]);
    cmp("grp_done", 1, q[IRQ_GROUP_BIT]);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    cmp("irq", 0, irq);
    wr(ADDR_IRQ_STATUS, 32'h3);
    rd(ADDR_IRQ_STATUS, 32'h0);
    $display("t_irq end");
  endtask : t_irq

  // scan a group, let it repeat, then stop it by clearing start
  task automatic t_scan(input logic [2:0] sel);
    logic [31:0] cs;
    cs = {24'h0, 4'b0111, 1'b1, sel};
    wr(ADDR_CTRL_STAT, cs);
    // flag only after the whole group, each input within the fast limit
    wirq((int'(sel[1:0]) + 1) * int'(CONV_CYC_FAST));
    for (int i = 0; i <= sel[1:0]; i++)
      rd(ADDR_RESULT_A + 32'(8 * i), res({sel[2], 2'(i)}));
    rd(ADDR_CTRL_STAT, cs | 32'h80);
    wr(ADDR_CTRL_STAT, cs);
    wirq(0);
    wr(ADDR_CTRL_STAT, cs & 32'hdf);
    quiet;
    rd(ADDR_CTRL_STAT, cs & 32'hdf);
    $display("t_scan end");
  endtask : t_scan

  task automatic t_stby;
    wr(ADDR_CTRL_STAT, 32'h3c);
    repeat (20) @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd(ADDR_CTRL_STAT, {24'h0, CS_RESET});
    rd(ADDR_RESULT_C, 32'h0);
    quiet;
    $display("t_stby end");
  endtask : t_stby

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    for (int i = 0; i < 8; i++) t_single(3'(i), i[0]);
    t_irq;
    // standby first, so the scans fill slots that were cleared
    t_stby;
    t_scan(3'b110);
    t_scan(3'b001);
    finish_test;
  end

  // hang guard, well beyond the expected run
  initial begin
    #400000;
    mismatches++;
    finish_test;
  end
endmodule : tb_adc_control_result_regs
